//--- logic/pdc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pdc_consts.svh"
// Functional notes
// [R1] coefficient in bits 6:0, 100 ppm/C
// [R2] sense resistance = gain*(1+tc*(T-25))
// [R3] bit 7 picks external sensors; host enables first
// [R4] one coefficient for both external sensors
// [R5] high-to-low gap signed ns, bits 15:8
// [R6] low-to-high gap signed ns, bits 7:0
// [R7] positive gap non-overlap, negative overlap
// [R8] adaptive high-to-low maximum defaults to 60 ns
// [R9] gap write then setup write loads maxima
// [R10] frozen gaps use stored gap values exactly; the code clamps them to the -10..60 ns span
// [R11] setup bits 14:8 minimum high-to-low, 2 ns
// [R12] setup bits 6:0 minimum low-to-high, 2 ns
// [R13] setup bit 15 freezes high-to-low gap
// [R14] setup bit 7 freezes low-to-high gap
// [R15] loop tuning four-byte block, residual, gain
// [R16] loop tuning bit 24 enables fast loop
// [R17] predecessor power-good needed before turn-on
// [R18] successor power-down starts delayed turn-off
// [R19] predecessor enable bit 15, id 12:8
// [R20] successor enable bit 7, id 4:0
// [R21] correction register is a byte transfer
// [R22] reads return last write, unused zero
module pdc_top
	import pdc_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR = 7'h20
)(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output var  logic        sda_out,
	output var  logic        sda_oe_n,
	input  wire logic        ext_sensor_en,
	input  wire logic [8:0]  temp_internal,
	input  wire logic [8:0]  temp_ext_a,
	input  wire logic [8:0]  temp_ext_b,
	input  wire logic [15:0] current_cal_gain,
	output var  logic [19:0] sense_resistance_a,
	output var  logic [19:0] sense_resistance_b,
	input  wire logic [15:0] adapt_gap,
	output var  logic [15:0] gap_drive,
	output var  logic [1:0]  gap_overlap,
	output var  logic        fast_loop_algorithm,
	output var  logic [15:0] loop_gain,
	output var  logic [7:0]  loop_residual,
	input  wire logic        rail_on_req,
	input  wire logic        gcb_evt_valid,
	input  wire logic        gcb_evt_pg,
	input  wire logic        gcb_evt_pd,
	input  wire logic [4:0]  gcb_evt_rail,
	input  wire logic [15:0] off_delay_cycles,
	output var  logic        rail_on
);

	// data bytes a command carries; zero marks an unknown command
	function automatic logic [2:0] cmd_len(input logic [7:0] c);
		case (c)
			`PDC_CMD_TEMP_CORR:  cmd_len = `PDC_LEN_BYTE; // R21
			`PDC_CMD_GAP_TIMES:  cmd_len = `PDC_LEN_WORD;
			`PDC_CMD_GAP_OPT:    cmd_len = `PDC_LEN_WORD;
			`PDC_CMD_RAIL_ORDER: cmd_len = `PDC_LEN_WORD;
			`PDC_CMD_LOOP_TUNE:  cmd_len = `PDC_LEN_BLOCK; // R15
			default:             cmd_len = `PDC_LEN_NONE;
		endcase
	endfunction : cmd_len

	// configuration registers
	logic [7:0]  temp_corr;
	logic [15:0] gap_times;
	logic [15:0] gap_opt;
	logic [31:0] loop_tune;
	logic [15:0] rail_order;
	logic [7:0]  next_temp_corr;
	logic [15:0] next_gap_times;
	logic [15:0] next_gap_opt;
	logic [31:0] next_loop_tune;
	logic [15:0] next_rail_order;
	logic        last_was_gap;
	logic        next_last_was_gap;
	logic        max_load;
	logic        next_max_load;

	// pin synchronisers and edge history
	logic scl_m;
	logic scl_s;
	logic scl_q;
	logic sda_m;
	logic sda_s;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	// serial engine state
	pdc_i2c_st_t st;
	pdc_i2c_st_t next_st;
	pdc_phase_t  phase;
	pdc_phase_t  next_phase;
	logic [3:0]  bitcnt;
	logic [3:0]  next_bitcnt;
	logic [7:0]  shreg;
	logic [7:0]  next_shreg;
	logic        rw;
	logic        next_rw;
	logic [7:0]  cmd;
	logic [7:0]  next_cmd;
	logic [2:0]  byte_idx;
	logic [2:0]  next_byte_idx;
	logic [39:0] wbytes;
	logic [39:0] next_wbytes;
	logic        wr_pend;
	logic        next_wr_pend;
	logic        next_oe_n;
	logic [39:0] rd_img;
	logic [7:0]  rd_byte;
	logic        byte_ok;
	logic [2:0]  idx_inc;

	// two stages on each pin before anything looks at it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_q <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			scl_q <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_q <= sda_s;
		end
	end

	// line events; start and stop are data edges while the clock is high
	always_comb begin
		scl_rise  = scl_s & ~scl_q;
		scl_fall  = ~scl_s & scl_q;
		bus_start = scl_s & scl_q & sda_q & ~sda_s;
		bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
		idx_inc   = byte_idx + 3'h1;
	end

	// read image, little-endian, block count byte first
	always_comb begin
		unique case (cmd_len(cmd))
			`PDC_LEN_BYTE:  rd_img = {32'h0000_0000, temp_corr}; // R22
			`PDC_LEN_BLOCK: rd_img = {loop_tune, `PDC_BLOCK_COUNT}; // R15
			`PDC_LEN_WORD: begin
				unique case (cmd)
					`PDC_CMD_GAP_TIMES: rd_img = {24'h00_0000, gap_times};
					`PDC_CMD_GAP_OPT:   rd_img = {24'h00_0000, gap_opt};
					default:            rd_img = {24'h00_0000, rail_order};
				endcase
			end
			default: rd_img = 40'h00_0000_0000;
		endcase
	end

	// byte about to be sent; reading past the end gives zero. the index is
	// taken from state, not from the engine's outputs, to keep the path acyclic
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < 5; i++) begin
			if (((st == PDC_I2C_MACK) ? idx_inc : 3'h0) == i[2:0]) begin
				rd_byte = rd_img[8*i +: 8];
			end
		end
	end

	// acknowledge only our address, known commands and bytes within length
	always_comb begin
		unique case (phase)
			PDC_PH_ADDR: byte_ok = (shreg[7:1] == BUS_ADDR);
			PDC_PH_CMD:  byte_ok = (cmd_len(shreg) != `PDC_LEN_NONE);
			default:     byte_ok = (byte_idx < cmd_len(cmd));
		endcase
	end

	// serial engine: the pin is only released or pulled low on a falling clock,
	// so data never changes while the host samples it
	always_comb begin
		next_st       = st;
		next_phase    = phase;
		next_bitcnt   = bitcnt;
		next_shreg    = shreg;
		next_rw       = rw;
		next_cmd      = cmd;
		next_byte_idx = byte_idx;
		next_wbytes   = wbytes;
		next_wr_pend  = 1'b0;
		next_oe_n     = sda_oe_n;
		if (bus_stop) begin
			next_st   = PDC_I2C_IDLE;
			next_oe_n = 1'b1;
		end else if (bus_start) begin
			// a repeated start keeps the command for the read that follows
			next_st     = PDC_I2C_RX;
			next_phase  = PDC_PH_ADDR;
			next_bitcnt = 4'h0;
			next_oe_n   = 1'b1;
		end else begin
			unique case (st)
				PDC_I2C_IDLE: begin
					next_oe_n = 1'b1;
				end
				PDC_I2C_RX: begin
					if (scl_rise) begin
						next_shreg  = {shreg[6:0], sda_s};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == 4'h8) begin
						next_oe_n = ~byte_ok;
						next_st   = byte_ok ? PDC_I2C_RACK : PDC_I2C_HOLD;
						if (phase == PDC_PH_ADDR) begin
							next_rw = shreg[0];
						end
					end
				end
				PDC_I2C_RACK: begin
					if (scl_fall) begin
						next_oe_n   = 1'b1;
						next_bitcnt = 4'h0;
						next_st     = PDC_I2C_RX;
						unique case (phase)
							PDC_PH_ADDR: begin
								if (rw) begin
									next_byte_idx = 3'h0;
									next_oe_n     = rd_byte[7];
									next_shreg    = {rd_byte[6:0], 1'b0};
									next_bitcnt   = 4'h1;
									next_st       = PDC_I2C_TX;
								end else begin
									next_phase = PDC_PH_CMD;
								end
							end
							PDC_PH_CMD: begin
								next_cmd      = shreg;
								next_byte_idx = 3'h0;
								next_phase    = PDC_PH_DATA;
							end
							default: begin
								next_wbytes[8*byte_idx +: 8] = shreg;
								next_byte_idx = idx_inc;
								next_wr_pend  = (idx_inc == cmd_len(cmd));
							end
						endcase
					end
				end
				PDC_I2C_TX: begin
					if (scl_fall) begin
						if (bitcnt == 4'h8) begin
							next_oe_n = 1'b1;
							next_st   = PDC_I2C_MACK;
						end else begin
							next_oe_n   = shreg[7];
							next_shreg  = {shreg[6:0], 1'b0};
							next_bitcnt = bitcnt + 4'h1;
						end
					end
				end
				PDC_I2C_MACK: begin
					if (scl_rise && sda_s) begin
						next_st = PDC_I2C_HOLD;
					end else if (scl_fall) begin
						next_byte_idx = idx_inc;
						next_oe_n     = rd_byte[7];
						next_shreg    = {rd_byte[6:0], 1'b0};
						next_bitcnt   = 4'h1;
						next_st       = PDC_I2C_TX;
					end
				end
				PDC_I2C_HOLD: begin
					next_oe_n = 1'b1;
				end
				default: begin
					next_st   = PDC_I2C_IDLE;
					next_oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st       <= PDC_I2C_IDLE;
			phase    <= PDC_PH_ADDR;
			bitcnt   <= 4'h0;
			shreg    <= 8'h00;
			rw       <= 1'b0;
			cmd      <= 8'h00;
			byte_idx <= 3'h0;
			wbytes   <= 40'h00_0000_0000;
			wr_pend  <= 1'b0;
			sda_oe_n <= 1'b1;
			sda_out  <= 1'b0;
		end else begin
			st       <= next_st;
			phase    <= next_phase;
			bitcnt   <= next_bitcnt;
			shreg    <= next_shreg;
			rw       <= next_rw;
			cmd      <= next_cmd;
			byte_idx <= next_byte_idx;
			wbytes   <= next_wbytes;
			wr_pend  <= next_wr_pend;
			sda_oe_n <= next_oe_n;
			sda_out  <= 1'b0;
		end
	end

	// register file: a completed write lands one cycle after its last ack
	always_comb begin
		next_temp_corr    = temp_corr;
		next_gap_times    = gap_times;
		next_gap_opt      = gap_opt;
		next_loop_tune    = loop_tune;
		next_rail_order   = rail_order;
		next_last_was_gap = last_was_gap;
		next_max_load     = 1'b0;
		if (wr_pend) begin
			next_last_was_gap = (cmd == `PDC_CMD_GAP_TIMES);
			unique case (cmd)
				`PDC_CMD_TEMP_CORR:  next_temp_corr = wbytes[7:0]; // R1 R3 R21
				`PDC_CMD_GAP_TIMES:  next_gap_times = wbytes[15:0]; // R5 R6
				`PDC_CMD_GAP_OPT: begin
					next_gap_opt  = wbytes[15:0]; // R11 R12 R13 R14
					next_max_load = last_was_gap; // R9
				end
				`PDC_CMD_RAIL_ORDER: begin
					next_rail_order = wbytes[15:0] & `PDC_MASK_RAIL_ORDER; // R19 R20 R22
				end
				`PDC_CMD_LOOP_TUNE: begin
					// a block whose count byte is not four is dropped whole
					if (wbytes[7:0] == `PDC_BLOCK_COUNT) begin
						next_loop_tune = wbytes[39:8] & `PDC_MASK_LOOP_TUNE; // R15 R22
					end
				end
				default: begin
					next_last_was_gap = last_was_gap;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			temp_corr    <= `PDC_RST_TEMP_CORR;
			gap_times    <= `PDC_RST_GAP_TIMES;
			gap_opt      <= `PDC_RST_GAP_OPT;
			loop_tune    <= `PDC_RST_LOOP_TUNE;
			rail_order   <= `PDC_RST_RAIL_ORDER;
			last_was_gap <= 1'b0;
			max_load     <= 1'b0;
		end else begin
			temp_corr    <= next_temp_corr;
			gap_times    <= next_gap_times;
			gap_opt      <= next_gap_opt;
			loop_tune    <= next_loop_tune;
			rail_order   <= next_rail_order;
			last_was_gap <= next_last_was_gap;
			max_load     <= next_max_load;
		end
	end

	// fast loop settings drive the control loop straight from the register
	always_comb begin
		fast_loop_algorithm = loop_tune[`PDC_FAST_EN_BIT]; // R16
		loop_gain           = loop_tune[15:0]; // R15
		loop_residual       = loop_tune[23:16]; // R15
	end

	// sense resistance per phase; selecting external sensors without the
	// enable falls back to the internal one rather than reading a dead input
	logic [8:0]  temp_sel [2];
	logic [19:0] res_q [2];
	logic        use_ext;

	always_comb begin
		use_ext     = temp_corr[`PDC_TC_SRC_BIT] & ext_sensor_en; // R3
		temp_sel[0] = use_ext ? temp_ext_a : temp_internal; // R4
		temp_sel[1] = use_ext ? temp_ext_b : temp_internal; // R4
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sense_resistance
			logic signed [9:0]  dt;
			logic signed [17:0] prod;
			logic signed [18:0] factor;
			logic [33:0]        scaled;
			logic [33:0]        quot;
			logic [19:0]        next_res;

			// the divide is by a constant; factor is clamped at zero so a
			// cold, steep coefficient cannot wrap into a huge resistance
			always_comb begin
				dt     = $signed({temp_sel[g][8], temp_sel[g]}) - $signed(`PDC_TEMP_REF_C); // R2
				prod   = $signed({1'b0, temp_corr[6:0]}) * dt; // R1
				factor = 19'(`PDC_TC_SCALE) + 19'(prod);
				if (factor[18]) begin
					scaled = 34'h0_0000_0000;
				end else begin
					scaled = current_cal_gain * factor[17:0]; // R2
				end
				quot     = scaled / 34'(`PDC_TC_SCALE);
				next_res = quot[19:0];
			end

			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					res_q[g] <= 20'h0_0000;
				end else begin
					res_q[g] <= next_res;
				end
			end
		end
	endgenerate

	always_comb begin
		sense_resistance_a = res_q[0];
		sense_resistance_b = res_q[1];
	end

	pdc_gap_ctrl u_gap (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.gap_times (gap_times),
		.gap_opt   (gap_opt),
		.max_load  (max_load),
		.adapt_gap (adapt_gap),
		.gap_out   (gap_drive),
		.overlap   (gap_overlap)
	);

	pdc_rail_seq u_seq (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.rail_order(rail_order),
		.on_req    (rail_on_req),
		.evt_valid (gcb_evt_valid),
		.evt_pg    (gcb_evt_pg),
		.evt_pd    (gcb_evt_pd),
		.evt_rail  (gcb_evt_rail),
		.off_delay (off_delay_cycles),
		.rail_on   (rail_on)
	);

endmodule : pdc_top
`default_nettype wire

//--- logic/pdc_consts.svh
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

// command codes of the configuration set
`define PDC_CMD_TEMP_CORR   8'hdc
`define PDC_CMD_GAP_TIMES   8'hdd
`define PDC_CMD_GAP_OPT     8'hde
`define PDC_CMD_LOOP_TUNE   8'hdf
`define PDC_CMD_RAIL_ORDER  8'he0

// transfer lengths in data bytes, block count byte included
`define PDC_LEN_NONE        3'h0
`define PDC_LEN_BYTE        3'h1
`define PDC_LEN_WORD        3'h2
`define PDC_LEN_BLOCK       3'h5
`define PDC_BLOCK_COUNT     8'h04

// field positions
`define PDC_TC_SRC_BIT      7
`define PDC_FREEZE_BIT      7
`define PDC_FAST_EN_BIT     24
`define PDC_PRED_EN_BIT     15
`define PDC_PRED_ID_LSB     8
`define PDC_SUCC_EN_BIT     7
`define PDC_SUCC_ID_LSB     0

// reset values and implemented-bit masks
`define PDC_RST_TEMP_CORR   8'h00
`define PDC_RST_GAP_TIMES   16'h0000
`define PDC_RST_GAP_OPT     16'h0000
`define PDC_RST_LOOP_TUNE   32'h0000_0000
`define PDC_RST_RAIL_ORDER  16'h0000
`define PDC_MASK_LOOP_TUNE  32'h01ff_ffff
`define PDC_MASK_RAIL_ORDER 16'h9f9f

// gap time limits in ns, two's complement
`define PDC_GAP_MIN_NS      8'hf6
`define PDC_GAP_MAX_NS      8'h3c
`define PDC_GAP_MAX_DEFAULT 8'h3c

// temperature correction scaling
`define PDC_TEMP_REF_C      10'h019
`define PDC_TC_UNIT_PPM     100
`define PDC_TC_SCALE        (1000000 / `PDC_TC_UNIT_PPM)

`endif

//--- logic/pdc_pkg.sv
`default_nettype none
package pdc_pkg;

	typedef enum logic [2:0] {
		PDC_I2C_IDLE = 3'b000,
		PDC_I2C_RX   = 3'b001,
		PDC_I2C_RACK = 3'b011,
		PDC_I2C_TX   = 3'b010,
		PDC_I2C_MACK = 3'b110,
		PDC_I2C_HOLD = 3'b111
	} pdc_i2c_st_t;

	typedef enum logic [1:0] {
		PDC_PH_ADDR = 2'b00,
		PDC_PH_CMD  = 2'b01,
		PDC_PH_DATA = 2'b11
	} pdc_phase_t;

	typedef enum logic [1:0] {
		PDC_SEQ_OFF    = 2'b00,
		PDC_SEQ_WAIT   = 2'b01,
		PDC_SEQ_ON     = 2'b11,
		PDC_SEQ_OFFDLY = 2'b10
	} pdc_seq_st_t;

endpackage : pdc_pkg
`default_nettype wire

//--- logic/pdc_gap_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "pdc_consts.svh"
module pdc_gap_ctrl
	import pdc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [15:0] gap_times,
	input  wire logic [15:0] gap_opt,
	input  wire logic        max_load,
	input  wire logic [15:0] adapt_gap,
	output var  logic [15:0] gap_out,
	output var  logic [1:0]  overlap
);

	// channel 1 is high-to-low (upper byte), channel 0 is low-to-high
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic signed [7:0] max_q;
			logic signed [7:0] next_max;
			logic signed [7:0] next_gap;
			logic signed [7:0] min_ns;
			logic signed [7:0] stored;
			logic signed [7:0] req;

			// new maxima only on the gap-times-then-setup write pair
			always_comb begin
				next_max = max_q;
				if (max_load) begin
					next_max = gap_times[8*g +: 8]; // R9
				end
			end

			// minimum is held in 2 ns steps, doubled by appending a zero bit, with no sign extension
			always_comb begin
				min_ns = {gap_opt[8*g+6 -: 7], 1'b0}; // R11 R12
				stored = gap_times[8*g +: 8]; // R5 R6
				req    = adapt_gap[8*g +: 8];
				if (gap_opt[8*g + `PDC_FREEZE_BIT]) begin // R13 R14
					// frozen: stored value, only trimmed if outside the legal span
					next_gap = stored; // R10
					if (stored < $signed(`PDC_GAP_MIN_NS)) begin
						next_gap = `PDC_GAP_MIN_NS;
					end else if (stored > $signed(`PDC_GAP_MAX_NS)) begin
						next_gap = `PDC_GAP_MAX_NS;
					end
				end else begin
					next_gap = req;
					if (req > max_q) begin
						next_gap = max_q; // R8
					end
					if (next_gap < min_ns) begin
						next_gap = min_ns;
					end
				end
			end

			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					max_q            <= `PDC_GAP_MAX_DEFAULT; // R8
					gap_out[8*g +: 8] <= 8'h00;
					overlap[g]       <= 1'b0;
				end else begin
					max_q            <= next_max;
					gap_out[8*g +: 8] <= next_gap;
					overlap[g]       <= next_gap[7]; // R7
				end
			end
		end
	endgenerate

endmodule : pdc_gap_ctrl
`default_nettype wire

//--- logic/pdc_rail_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "pdc_consts.svh"
module pdc_rail_seq
	import pdc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [15:0] rail_order,
	input  wire logic        on_req,
	input  wire logic        evt_valid,
	input  wire logic        evt_pg,
	input  wire logic        evt_pd,
	input  wire logic [4:0]  evt_rail,
	input  wire logic [15:0] off_delay,
	output var  logic        rail_on
);

	pdc_seq_st_t st;
	pdc_seq_st_t next_st;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic        next_on;
	logic        pred_en;
	logic        succ_en;
	logic        pred_pg;
	logic        succ_pd;

	// events are matched against the programmed peer identifiers
	always_comb begin
		pred_en = rail_order[`PDC_PRED_EN_BIT]; // R19
		succ_en = rail_order[`PDC_SUCC_EN_BIT]; // R20
		pred_pg = evt_valid & evt_pg
			& (evt_rail == rail_order[`PDC_PRED_ID_LSB +: 5]); // R19
		succ_pd = evt_valid & evt_pd
			& (evt_rail == rail_order[`PDC_SUCC_ID_LSB +: 5]); // R20
	end

	// a missing peer degrades to the plain enable alone
	always_comb begin
		next_st  = st;
		next_cnt = cnt;
		unique case (st)
			PDC_SEQ_OFF: begin
				if (on_req) begin
					next_st = pred_en ? PDC_SEQ_WAIT : PDC_SEQ_ON; // R17
				end
			end
			PDC_SEQ_WAIT: begin
				if (!on_req) begin
					next_st = PDC_SEQ_OFF;
				end else if (pred_pg) begin
					next_st = PDC_SEQ_ON; // R17
				end
			end
			PDC_SEQ_ON: begin
				if (succ_en ? succ_pd : !on_req) begin // R18
					next_st  = PDC_SEQ_OFFDLY;
					next_cnt = off_delay;
				end
			end
			PDC_SEQ_OFFDLY: begin
				if (cnt == 16'h0000) begin
					next_st = PDC_SEQ_OFF; // R18
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
		endcase
		next_on = (next_st == PDC_SEQ_ON) || (next_st == PDC_SEQ_OFFDLY);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st      <= PDC_SEQ_OFF;
			cnt     <= 16'h0000;
			rail_on <= 1'b0;
		end else begin
			st      <= next_st;
			cnt     <= next_cnt;
			rail_on <= next_on;
		end
	end

endmodule : pdc_rail_seq
`default_nettype wire

//--- dv/pdc_sva.sv
`timescale 1ns/100ps
`default_nettype none
// watches the block from its pins only
module pdc_sva (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        scl_in,
	input wire logic        sda_oe_n,
	input wire logic [8:0]  temp_internal,
	input wire logic [8:0]  temp_ext_a,
	input wire logic [8:0]  temp_ext_b,
	input wire logic [15:0] current_cal_gain,
	input wire logic [19:0] sense_resistance_a,
	input wire logic [19:0] sense_resistance_b,
	input wire logic [15:0] gap_drive,
	input wire logic [1:0]  gap_overlap,
	input wire logic        rail_on_req,
	input wire logic        rail_on
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// all sensors at the reference point, so the correction term vanishes
	sequence s_ref;
		temp_internal == 9'h019 && temp_ext_a == 9'h019 && temp_ext_b == 9'h019;
	endsequence
	// rail down and nobody asking for it
	sequence s_idle;
		!rail_on && !rail_on_req;
	endsequence
	AST_SENSE_A: assert property (
		s_ref |=> sense_resistance_a == {4'h0, $past(current_cal_gain)})
		else $error("sense a differs from gain");
	AST_SENSE_B: assert property (
		s_ref |=> sense_resistance_b == {4'h0, $past(current_cal_gain)})
		else $error("sense b differs from gain");
	AST_OVERLAP: assert property (
		gap_overlap == {gap_drive[15], gap_drive[7]})
		else $error("overlap flags disagree with gaps");
	AST_HL_SPAN: assert property (
		$signed(gap_drive[15:8]) >= $signed(8'hf6) && $signed(gap_drive[15:8]) <= $signed(8'h3c))
		else $error("high to low gap out of span");
	AST_LH_SPAN: assert property (
		$signed(gap_drive[7:0]) >= $signed(8'hf6) && $signed(gap_drive[7:0]) <= $signed(8'h3c))
		else $error("low to high gap out of span");
	AST_ON_REQ: assert property (
		$rose(rail_on) |-> $past(rail_on_req))
		else $error("rail came up unrequested");
	AST_STAY_OFF: assert property (
		s_idle |=> !rail_on)
		else $error("rail rose with request low");
	AST_ACK_LOW: assert property (
		$changed(sda_oe_n) |-> !scl_in)
		else $error("data pin moved while clock high");
endmodule : pdc_sva
bind pdc_top pdc_sva i_sva (.clk_sys, .rstn, .scl_in, .sda_oe_n, .temp_internal, .temp_ext_a,
	.temp_ext_b, .current_cal_gain, .sense_resistance_a, .sense_resistance_b, .gap_drive,
	.gap_overlap, .rail_on_req, .rail_on);
`default_nettype wire

//--- dv/pdc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// bus host and peer rails on the far side of the block
module pdc_host_model #(
	parameter logic [6:0] ADDR = 7'h20
)(
	input  wire logic       clk_sys,
	input  wire logic       sda_out,
	input  wire logic       sda_oe_n,
	output var  logic       scl_in,
	output var  logic       sda_in,
	output var  logic [7:0] evt
);
	logic sda_drv = 1'b1;
	// pulled-up wire: low while either party pulls it
	assign sda_in = sda_drv & (sda_oe_n | sda_out);
	initial begin
		scl_in = 1'b1;
		evt = 8'h00;
	end
	// quarter bit; clock low spans two, leaving room for the pin lag
	task automatic q;
		repeat (6) @(negedge clk_sys);
	endtask : q
	task automatic bit_io(input logic b, output logic r);
		q();
		sda_drv = b;
		q();
		scl_in = 1'b1;
		q();
		r = sda_in;
		q();
		scl_in = 1'b0;
	endtask : bit_io
	// start and stop: data moves while the clock is high
	task automatic edge2(input logic a, input logic b);
		q();
		sda_drv = a;
		q();
		scl_in = 1'b1;
		q();
		sda_drv = b;
		q();
		scl_in = b;
	endtask : edge2
	task automatic tx(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(v[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : tx
	task automatic xfer(input logic [7:0] cmd, input int n, input logic rd,
		inout logic [39:0] d, output logic nak);
		logic a;
		logic b;
		edge2(1'b1, 1'b0);
		tx({ADDR, 1'b0}, a);
		tx(cmd, b);
		nak = !(a & b);
		if (rd) begin
			edge2(1'b1, 1'b0);
			tx({ADDR, 1'b1}, a);
			nak |= !a;
			// every byte but the last is acknowledged, so the slave keeps sending
			for (int i = 0; i < n; i++) begin
				for (int j = 7; j >= 0; j--) bit_io(1'b1, d[8 * i + j]);
				bit_io(i == n - 1, a);
			end
		end else begin
			for (int i = 0; i < n; i++) begin
				tx(d[8 * i +: 8], a);
				nak |= !a;
			end
		end
		edge2(1'b0, 1'b1);
	endtask : xfer
	// one-cycle group bus event {valid, pg, pd, id}, scrambled once gone
	task automatic send(input logic [7:0] e);
		@(negedge clk_sys);
		evt = e;
		@(negedge clk_sys);
		evt = ~e & 8'h7f;
	endtask : send
endmodule : pdc_host_model
`default_nettype wire

//--- dv/test_pol_deadtime_sequence_config.sv
`timescale 1ns/100ps
`default_nettype none
module test_pol_deadtime_sequence_config;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        scl_in, sda_in, sda_out, sda_oe_n, fast_loop_algorithm, rail_on;
	logic        ext_sensor_en = 1'b0;
	logic        rail_on_req = 1'b0;
	logic [8:0]  temp_internal = 9'h019;
	logic [8:0]  temp_ext_a = 9'h019;
	logic [8:0]  temp_ext_b = 9'h019;
	logic [15:0] current_cal_gain = 16'h03e8;
	logic [15:0] adapt_gap = 16'h7f7f;
	logic [15:0] off_delay_cycles = 16'h0005;
	logic [19:0] sense_resistance_a, sense_resistance_b;
	logic [15:0] gap_drive, loop_gain;
	logic [1:0]  gap_overlap;
	logic [7:0]  loop_residual, evt;
	logic [39:0] d;
	logic        nak;
	int          err_total = 0;
	int          samples_checked = 0;
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	pdc_top i_dut (.clk_sys, .rstn, .scl_in, .sda_in, .sda_out, .sda_oe_n, .ext_sensor_en,
		.temp_internal, .temp_ext_a, .temp_ext_b, .current_cal_gain, .sense_resistance_a,
		.sense_resistance_b, .adapt_gap, .gap_drive, .gap_overlap, .fast_loop_algorithm,
		.loop_gain, .loop_residual, .rail_on_req, .gcb_evt_valid(evt[7]), .gcb_evt_pg(evt[6]),
		.gcb_evt_pd(evt[5]), .gcb_evt_rail(evt[4:0]), .off_delay_cycles, .rail_on);
	pdc_host_model i_host (.clk_sys, .sda_out, .sda_oe_n, .scl_in, .sda_in, .evt);
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk
	// register access; a write also compares the refusal seen on the bus
	task automatic wr(input logic [7:0] cmd, input int n, input logic [39:0] v, input logic rf);
		d = v;
		i_host.xfer(cmd, n, 1'b0, d, nak);
		chk(40'(nak), 40'(rf));
	endtask : wr
	task automatic rd(input logic [7:0] cmd, input int n, input logic [39:0] exp);
		d = 40'h0;
		i_host.xfer(cmd, n, 1'b1, d, nak);
		chk({d[39:1], d[0] | nak}, exp);
	endtask : rd
	task automatic gap(input logic [15:0] a, input logic [17:0] exp);
		adapt_gap = a;
		repeat (4) @(negedge clk_sys);
		chk(40'({gap_overlap, gap_drive}), 40'(exp));
	endtask : gap
	task automatic rail(input int n, input logic exp);
		repeat (n) @(negedge clk_sys);
		chk(40'(rail_on), 40'(exp));
	endtask : rail
	task automatic wrap_up;
		$display("checked %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	// bus transfers dominate the run; this allows about four times their total
	initial begin
		repeat (80000) @(posedge clk_sys);
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (8) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (4) @(negedge clk_sys);
		rd(8'hdd, 2, 40'h0);
		rd(8'hdf, 5, 40'h04);
		// coefficient 5 with the external pair apart from the reference
		{temp_ext_a, temp_ext_b, ext_sensor_en} = {9'h023, 9'h00f, 1'b1};
		wr(8'hdc, 1, 40'h85, 1'b0);
		rd(8'hdc, 1, 40'h85);
		chk(40'({sense_resistance_a, sense_resistance_b}), 40'h003ed003e3);
		ext_sensor_en = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk(40'(sense_resistance_a), 40'h3e8);
		// frozen gaps ignore the adaptive request
		wr(8'hde, 2, 40'h8080, 1'b0);
		wr(8'hdd, 2, 40'hfb1e, 1'b0);
		gap(16'h7f7f, 18'h2fb1e);
		wr(8'hdd, 2, 40'h3cf6, 1'b0);
		gap(16'h0000, 18'h13cf6);
		// an intervening write keeps the default maxima
		wr(8'hdc, 1, 40'h05, 1'b0);
		wr(8'hde, 2, 40'h0000, 1'b0);
		gap(16'h7f7f, 18'h03c3c);
		gap(16'hf0f0, 18'h00000);
		wr(8'hde, 2, 40'h0a05, 1'b0);
		gap(16'hf0f0, 18'h0140a);
		wr(8'hdd, 2, 40'h2819, 1'b0);
		wr(8'hde, 2, 40'h0000, 1'b0);
		gap(16'h7f7f, 18'h02819);
		wr(8'hdf, 5, 40'h01ab123404, 1'b0);
		chk(40'({fast_loop_algorithm, loop_residual, loop_gain}), 40'h1ab1234);
		wr(8'hdf, 5, 40'hfe5a678904, 1'b0);
		rd(8'hdf, 5, 40'h005a678904);
		chk(40'(fast_loop_algorithm), 40'h0);
		// no neighbours: the request alone moves the rail
		rail_on_req = 1'b1;
		rail(3, 1'b1);
		rail_on_req = 1'b0;
		rail(12, 1'b0);
		wr(8'he1, 2, 40'hffff, 1'b1);
		wr(8'he0, 2, 40'hffff, 1'b0);
		rd(8'he0, 2, 40'h9f9f);
		wr(8'he0, 2, 40'h8385, 1'b0);
		rail_on_req = 1'b1;
		i_host.send(8'hc4);
		rail(3, 1'b0);
		i_host.send(8'hc3);
		rail(3, 1'b1);
		rail_on_req = 1'b0;
		i_host.send(8'ha3);
		rail(8, 1'b1);
		i_host.send(8'ha5);
		rail(2, 1'b1);
		rail(10, 1'b0);
		wrap_up();
	end
endmodule : test_pol_deadtime_sequence_config
`default_nettype wire
